// ===== pkg/scs_pkg.sv
`default_nettype none
package scs_pkg;
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned TENTH_S_CYC    = CLK_HZ / 10;
    localparam int unsigned MS_CYC         = CLK_HZ / 1000;
    // Register byte offsets
    localparam logic [4:0] ADR_STATION  = 5'h00;
    localparam logic [4:0] ADR_RATE     = 5'h04;
    localparam logic [4:0] ADR_PARITY   = 5'h08;
    localparam logic [4:0] ADR_REACT    = 5'h0C;
    localparam logic [4:0] ADR_TOEN     = 5'h10;
    localparam logic [4:0] ADR_DELAY    = 5'h14;
    localparam logic [4:0] ADR_RTS      = 5'h18;
    localparam logic [4:0] ADR_PROTO    = 5'h1C;
    // Second bank offsets (5-bit window wraps; use upper decode bit)
    localparam logic [5:0] ADR6_LOSS    = 6'h20;
    localparam logic [5:0] ADR6_STATUS  = 6'h24;
    localparam logic [5:0] ADR6_IRQ     = 6'h28;
    localparam logic [5:0] ADR6_MASK    = 6'h2C;
    localparam logic [5:0] ADR6_ACTIVE  = 6'h30;
    // Reset values
    localparam logic [7:0] RST_STATION  = 8'h1F;
    localparam logic [2:0] RST_RATE     = 3'h3;
    localparam logic [1:0] RST_PARITY   = 2'h0;
    localparam logic [2:0] RST_REACT    = 3'h3;
    localparam logic       RST_TOEN     = 1'b1;
    localparam logic [6:0] RST_DELAY    = 7'h05;
    localparam logic       RST_RTS      = 1'b1;
    localparam logic [1:0] RST_PROTO    = 2'h0;
    localparam logic [9:0] RST_LOSS     = 10'h014;
    // Limits
    localparam logic [7:0] MAX_ADR_P0   = 8'h20;
    localparam logic [7:0] MAX_ADR_P1   = 8'hFF;
    localparam logic [7:0] MAX_ADR_P2   = 8'h63;
    localparam logic [6:0] MIN_DELAY    = 7'h05;
    localparam logic [6:0] MAX_DELAY    = 7'h41;
    localparam logic [9:0] MAX_LOSS_P01 = 10'h064;
    localparam logic [9:0] MAX_LOSS_P2  = 10'h384;
    localparam logic [2:0] MAX_RATE     = 3'h4;
    localparam logic [1:0] MAX_PARITY   = 2'h2;
    localparam logic [1:0] MAX_PROTO    = 2'h2;
    localparam logic [2:0] REACT_ALARM  = 3'h3;
    localparam logic [2:0] REACT_PRESET = 3'h4;
    // Status bit positions
    localparam int unsigned ST_FAULT    = 0;
    localparam int unsigned ST_RX       = 1;
    localparam int unsigned ST_TXDONE   = 2;
    localparam int unsigned ST_REJECT   = 3;
    localparam int unsigned ST_W        = 4;
    typedef enum logic [2:0] {
        SCS_REACT_RAMP, SCS_REACT_COAST, SCS_REACT_FAST,
        SCS_REACT_ALARM, SCS_REACT_PRESET
    } scs_react_t;
endpackage : scs_pkg
`default_nettype wire

// ===== hw/scs_tick.sv
`default_nettype none
// Free-running strobe every DIV clock cycles
module scs_tick #(
    parameter int unsigned DIV = 40_000
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    output logic      tick_o
);
    logic [$clog2(DIV)-1:0] cnt;

    always_ff @(posedge clk_i) begin
        if (rst_i || cnt == ($clog2(DIV))'(DIV - 1)) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_o <= 1'b0;
        end else begin
            tick_o <= (cnt == ($clog2(DIV))'(DIV - 1));
        end
    end
endmodule : scs_tick
`default_nettype wire

// ===== hw/scs_supervisor.sv
`default_nettype none
module scs_supervisor #(
    parameter int unsigned MS_DIV    = scs_pkg::MS_CYC,
    parameter int unsigned TENTH_DIV = scs_pkg::TENTH_S_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Framing engine side
    input  wire logic        msg_valid_i,
    input  wire logic        tx_req_i,
    input  wire logic        tx_busy_i,
    output logic             tx_go_o,
    output logic             rts_o,
    output logic             port_enable_o,
    output logic [2:0]       bit_rate_o,
    output logic [1:0]       parity_o,
    output logic [1:0]       protocol_o,
    output logic [7:0]       station_addr_o,
    // Drive control side
    output logic             comm_fault_o,
    output logic [2:0]       stop_method_o,
    output logic             irq_o
);
    // Software-written settings
    logic [7:0] station_address_param;
    logic [2:0] bit_rate_param;
    logic [1:0] parity_param;
    logic [2:0] comm_error_reaction_param;
    logic       timeout_enable_param;
    logic [6:0] reply_delay_param;
    logic       rts_policy_param;
    logic [1:0] protocol_choice_param;
    logic [9:0] loss_timeout_param;
    // Values latched once after reset
    logic [7:0] act_addr;
    logic [2:0] act_rate;
    logic [1:0] act_parity;
    logic       latched;
    logic       rst_q;

    localparam int unsigned ST_W_C = scs_pkg::ST_W;
    logic [ST_W_C-1:0] status;
    logic [ST_W_C-1:0] mask;

    logic       wr;
    logic       rd_ok;
    logic [7:0] addr_max;
    logic [9:0] loss_max;
    logic       ms_tick;
    logic       tenth_tick;
    logic       active;

    // Reply wait, loss timer and event edge-detect state
    logic [6:0] wait_ms;
    logic       waiting;
    logic       tx_active;
    logic [9:0] loss_cnt;
    logic       fault;
    logic       fault_q;
    logic       busy_q;
    logic       reject_ev;

    scs_tick #(.DIV(MS_DIV)) u_ms (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (ms_tick)
    );

    scs_tick #(.DIV(TENTH_DIV)) u_tenth (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_o (tenth_tick)
    );

    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];

    // Address ceiling depends on live protocol choice
    always_comb begin
        case (protocol_choice_param)
            2'h1:    addr_max = scs_pkg::MAX_ADR_P1;
            2'h2:    addr_max = scs_pkg::MAX_ADR_P2;
            default: addr_max = scs_pkg::MAX_ADR_P0;
        endcase
        loss_max = (protocol_choice_param == 2'h2) ? scs_pkg::MAX_LOSS_P2
                                                   : scs_pkg::MAX_LOSS_P01;
    end

    // Out-of-range writes are dropped and flagged
    always_comb begin
        rd_ok = 1'b1;
        case (wb_adr_i)
            {1'b0, scs_pkg::ADR_STATION}:
                rd_ok = wb_dat_i[7:0] <= addr_max;
            {1'b0, scs_pkg::ADR_RATE}:
                rd_ok = wb_dat_i[31:3] == '0
                        && wb_dat_i[2:0] <= scs_pkg::MAX_RATE;
            {1'b0, scs_pkg::ADR_PARITY}:
                rd_ok = wb_dat_i[31:2] == '0
                        && wb_dat_i[1:0] <= scs_pkg::MAX_PARITY;
            {1'b0, scs_pkg::ADR_REACT}:
                rd_ok = wb_dat_i[2:0] < scs_pkg::REACT_PRESET
                        || (wb_dat_i[2:0] == scs_pkg::REACT_PRESET
                            && protocol_choice_param != 2'h0);
            {1'b0, scs_pkg::ADR_DELAY}:
                rd_ok = wb_dat_i[6:0] >= scs_pkg::MIN_DELAY
                        && wb_dat_i[6:0] <= scs_pkg::MAX_DELAY;
            {1'b0, scs_pkg::ADR_PROTO}:
                rd_ok = wb_dat_i[1:0] <= scs_pkg::MAX_PROTO;
            scs_pkg::ADR6_LOSS:
                rd_ok = wb_dat_i[9:0] <= loss_max;
            default: rd_ok = 1'b1;
        endcase
    end

    assign reject_ev = wr && !rd_ok;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            comm_error_reaction_param <= scs_pkg::RST_REACT;
            timeout_enable_param      <= scs_pkg::RST_TOEN;
            reply_delay_param         <= scs_pkg::RST_DELAY;
            rts_policy_param          <= scs_pkg::RST_RTS;
            protocol_choice_param     <= scs_pkg::RST_PROTO;
            loss_timeout_param        <= scs_pkg::RST_LOSS;
            mask                      <= '0;
        end else if (wr && rd_ok) begin
            case (wb_adr_i)
                {1'b0, scs_pkg::ADR_REACT}:
                    comm_error_reaction_param <= wb_dat_i[2:0];
                {1'b0, scs_pkg::ADR_TOEN}:
                    timeout_enable_param <= wb_dat_i[0];
                {1'b0, scs_pkg::ADR_DELAY}:
                    reply_delay_param <= wb_dat_i[6:0];
                {1'b0, scs_pkg::ADR_RTS}:
                    rts_policy_param <= wb_dat_i[0];
                {1'b0, scs_pkg::ADR_PROTO}:
                    protocol_choice_param <= wb_dat_i[1:0];
                scs_pkg::ADR6_LOSS:
                    loss_timeout_param <= {wb_dat_i[9:8] & {2{wb_sel_i[1]}},
                                           wb_dat_i[7:0]};
                scs_pkg::ADR6_MASK:
                    mask <= wb_dat_i[ST_W_C-1:0];
                default: ;
            endcase
        end
    end

    // Power-up reset must span two edges: a longer reset restores the
    // link defaults, a one-edge reset keeps them so new values apply
    always_ff @(posedge clk_i) begin
        rst_q <= rst_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i && rst_q) begin
            station_address_param <= scs_pkg::RST_STATION;
            bit_rate_param        <= scs_pkg::RST_RATE;
            parity_param          <= scs_pkg::RST_PARITY;
        end else if (!rst_i && wr && rd_ok) begin
            case (wb_adr_i)
                {1'b0, scs_pkg::ADR_STATION}:
                    station_address_param <= wb_dat_i[7:0];
                {1'b0, scs_pkg::ADR_RATE}:
                    bit_rate_param <= wb_dat_i[2:0];
                {1'b0, scs_pkg::ADR_PARITY}:
                    parity_param <= wb_dat_i[1:0];
                default: ;
            endcase
        end
    end

    // Link settings captured once, one cycle after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latched    <= 1'b0;
            act_addr   <= scs_pkg::RST_STATION;
            act_rate   <= scs_pkg::RST_RATE;
            act_parity <= scs_pkg::RST_PARITY;
        end else if (!latched) begin
            latched    <= 1'b1;
            act_addr   <= station_address_param;
            act_rate   <= bit_rate_param;
            act_parity <= parity_param;
        end
    end

    assign active = act_addr != 8'h00;

    // Reply delay: counts whole ms ticks after a received message
    always_ff @(posedge clk_i) begin
        if (rst_i || !active) begin
            waiting <= 1'b0;
            wait_ms <= '0;
        end else if (msg_valid_i) begin
            waiting <= 1'b1;
            wait_ms <= reply_delay_param;
        end else if (waiting && ms_tick) begin
            if (wait_ms <= 7'h01) begin
                waiting <= 1'b0;
                wait_ms <= '0;
            end else begin
                wait_ms <= wait_ms - 7'h01;
            end
        end
    end

    // Grant transmit once the wait has expired
    // Message cycle itself blocks the grant, before the wait is loaded
    assign tx_go_o = active && tx_req_i && !waiting
                     && !msg_valid_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_active <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            tx_active <= active && (tx_go_o || tx_busy_i);
            busy_q    <= tx_busy_i;
        end
    end

    // RTS from a flop; disabled port never asserts it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rts_o <= 1'b0;
        end else if (!active) begin
            rts_o <= 1'b0;
        end else if (!rts_policy_param) begin
            rts_o <= 1'b1;
        end else begin
            rts_o <= tx_go_o || tx_busy_i;
        end
    end

    // Loss timer in tenths of a second
    always_ff @(posedge clk_i) begin
        if (rst_i || !timeout_enable_param || !active || msg_valid_i) begin
            loss_cnt <= '0;
        end else if (tenth_tick && !fault) begin
            loss_cnt <= loss_cnt + 10'h001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !timeout_enable_param || !active) begin
            fault <= 1'b0;
        end else if (msg_valid_i) begin
            fault <= 1'b0;
        end else if (loss_cnt > loss_timeout_param
                     || (tenth_tick && loss_cnt == loss_timeout_param)) begin
            fault <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_q <= 1'b0;
        end else begin
            fault_q <= fault;
        end
    end

    // Sticky status; a new event beats a same-cycle clear
    logic [ST_W_C-1:0] ev;
    logic [ST_W_C-1:0] clr;
    always_comb begin
        ev = '0;
        ev[scs_pkg::ST_FAULT]  = fault && !fault_q;
        ev[scs_pkg::ST_RX]     = msg_valid_i && active;
        ev[scs_pkg::ST_TXDONE] = busy_q && !tx_busy_i;
        ev[scs_pkg::ST_REJECT] = reject_ev;
        clr = (wr && wb_adr_i == scs_pkg::ADR6_STATUS)
              ? wb_dat_i[ST_W_C-1:0] : '0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= '0;
        end else begin
            status <= (status & ~clr) | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status & mask);
        end
    end

    // Drive-side reaction to a loss fault
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            comm_fault_o  <= 1'b0;
            stop_method_o <= scs_pkg::REACT_ALARM;
        end else begin
            comm_fault_o  <= fault;
            stop_method_o <= comm_error_reaction_param;
        end
    end

    assign port_enable_o  = active;
    assign bit_rate_o     = act_rate;
    assign parity_o       = act_parity;
    assign protocol_o     = protocol_choice_param;
    assign station_addr_o = act_addr;

    // Wishbone: one-cycle ack, registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
            case (wb_adr_i)
                {1'b0, scs_pkg::ADR_STATION}:
                    wb_dat_o <= {24'h0, station_address_param};
                {1'b0, scs_pkg::ADR_RATE}:
                    wb_dat_o <= {29'h0, bit_rate_param};
                {1'b0, scs_pkg::ADR_PARITY}:
                    wb_dat_o <= {30'h0, parity_param};
                {1'b0, scs_pkg::ADR_REACT}:
                    wb_dat_o <= {29'h0, comm_error_reaction_param};
                {1'b0, scs_pkg::ADR_TOEN}:
                    wb_dat_o <= {31'h0, timeout_enable_param};
                {1'b0, scs_pkg::ADR_DELAY}:
                    wb_dat_o <= {25'h0, reply_delay_param};
                {1'b0, scs_pkg::ADR_RTS}:
                    wb_dat_o <= {31'h0, rts_policy_param};
                {1'b0, scs_pkg::ADR_PROTO}:
                    wb_dat_o <= {30'h0, protocol_choice_param};
                scs_pkg::ADR6_LOSS:
                    wb_dat_o <= {22'h0, loss_timeout_param};
                scs_pkg::ADR6_STATUS:
                    wb_dat_o <= {28'h0, status};
                scs_pkg::ADR6_MASK:
                    wb_dat_o <= {28'h0, mask};
                scs_pkg::ADR6_ACTIVE:
                    wb_dat_o <= {18'h0, tx_active, act_parity, act_rate,
                                 act_addr};
                default:
                    wb_dat_o <= '0;
            endcase
        end
    end
endmodule : scs_supervisor
`default_nettype wire

// ===== dv/scs_supervisor_monitor.sv
`default_nettype none
module scs_supervisor_check (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       msg_valid_i,
    input wire logic       tx_req_i,
    input wire logic       tx_busy_i,
    input wire logic       tx_go_o,
    input wire logic       rts_o,
    input wire logic       port_enable_o,
    input wire logic [2:0] bit_rate_o,
    input wire logic [1:0] parity_o,
    input wire logic [7:0] station_addr_o,
    input wire logic       comm_fault_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_port_off_quiet: assert property (
        !port_enable_o && $past(!port_enable_o) |-> !tx_go_o && !rts_o)
        else $error("disabled port drives go or rts");
    a_go_needs_req: assert property (
        tx_go_o |-> tx_req_i && port_enable_o)
        else $error("grant without request");
    a_reply_wait: assert property (msg_valid_i |-> !tx_go_o [*8])
        else $error("reply granted too soon after message");
    a_rts_on_busy: assert property (
        port_enable_o && tx_busy_i |=> rts_o)
        else $error("rts low while sending");
    a_fault_after_msg: assert property (
        msg_valid_i |-> ##2 !comm_fault_o)
        else $error("fault raised right after a message");
    a_link_stable: assert property (
        !$past(rst_i) && !$past(rst_i, 2) |-> $stable(bit_rate_o)
        && $stable(parity_o) && $stable(station_addr_o))
        else $error("link settings changed without reset");
endmodule : scs_supervisor_check
bind scs_supervisor scs_supervisor_check u_scs_supervisor_check (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .msg_valid_i,
    .tx_req_i, .tx_busy_i, .tx_go_o, .rts_o, .port_enable_o,
    .bit_rate_o, .parity_o, .station_addr_o, .comm_fault_o
);
`default_nettype wire

// ===== dv/scs_framer_model.sv
`default_nettype none
module scs_framer_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic send_i,
    input  wire logic slow_i,
    input  wire logic tx_go_i,
    output logic      msg_valid_o,
    output logic      tx_req_o,
    output logic      tx_busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] busy_cnt;
    always_ff @(posedge clk_i) begin
        msg_valid_o <= send_i;
        if (rst_i) begin
            tx_req_o  <= 1'h0;
            tx_busy_o <= 1'h0;
            busy_cnt  <= 5'h00;
        end else if (send_i) begin
            tx_req_o <= 1'h1;
        end else if (tx_req_o && tx_go_i) begin
            // Request held until the grant is seen
            tx_req_o  <= 1'h0;
            tx_busy_o <= 1'h1;
            busy_cnt  <= slow_i ? 5'h14 : 5'h03;
        end else if (busy_cnt != 5'h00) begin
            busy_cnt <= busy_cnt - 5'h01;
        end else begin
            tx_busy_o <= 1'h0;
        end
    end
endmodule : scs_framer_model
`default_nettype wire

// ===== dv/scs_supervisor_test.sv
`default_nettype none
module scs_supervisor_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, send, slow;
    logic [5:0]  wb_adr;
    logic [31:0] wb_dat, wb_dat_o;
    logic        wb_ack_o, msg_valid, tx_req, tx_busy, tx_go_o, rts_o;
    logic        port_enable_o, comm_fault_o, irq_o;
    logic [2:0]  bit_rate_o, stop_method_o;
    logic [1:0]  parity_o, protocol_o;
    logic [7:0]  station_addr_o;
    logic [31:0] exp_q[$];
    int          err_total, comparisons, seed, n;
    logic [31:0] dflt [9] = '{32'h1F, 32'h3, 32'h0, 32'h3, 32'h1,
                              32'h5, 32'h1, 32'h0, 32'h14};
    // Short dividers: 10 cycles a ms, 40 cycles a tenth
    scs_supervisor #(.MS_DIV(10), .TENTH_DIV(40)) u_scs_supervisor (
        .clk_i, .rst_i, .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
        .wb_dat_i(wb_dat), .wb_dat_o, .wb_ack_o, .msg_valid_i(msg_valid),
        .tx_req_i(tx_req), .tx_busy_i(tx_busy), .tx_go_o, .rts_o,
        .port_enable_o, .bit_rate_o, .parity_o, .protocol_o,
        .station_addr_o, .comm_fault_o, .stop_method_o, .irq_o);
    scs_framer_model u_scs_framer_model (
        .clk_i, .rst_i, .send_i(send), .slow_i(slow), .tx_go_i(tx_go_o),
        .msg_valid_o(msg_valid), .tx_req_o(tx_req), .tx_busy_o(tx_busy));
    initial begin
        clk_i = 1'h0;
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we  <= w;
        wb_adr <= a;
        wb_dat <= d;
        do begin
            @(posedge clk_i);
        end while (!wb_ack_o);
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'h0, a, 32'h0);
    endtask : rd
    task automatic lim(input logic [1:0] p, input logic [5:0] a,
                       input logic [31:0] v, input logic [31:0] e);
        bus(1'h1, 6'h1C, 32'(p));
        bus(1'h1, a, v);
        rd(a, e);
    endtask : lim
    task automatic pulse_msg;
        @(posedge clk_i);
        send <= 1'h1;
        @(posedge clk_i);
        send <= 1'h0;
    endtask : pulse_msg
    task automatic reply(input int d, input logic pol, input logic slw);
        logic rts_seen;
        rts_seen = 1'h0;
        n = 0;
        slow <= slw;
        pulse_msg();
        while (!tx_go_o && n < 1000) begin
            @(posedge clk_i);
            n++;
            rts_seen |= rts_o;
        end
        chk("reply_wait", 32'(n >= (d-1)*10 && n <= d*10+5), 32'h1);
        chk("rts_wait", 32'(rts_seen), 32'(!pol));
        repeat (3) @(posedge clk_i);
        chk("rts_busy", 32'(rts_o), 32'h1);
        n = 0;
        while (tx_busy && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        repeat (2) @(posedge clk_i);
        chk("rts_after", 32'(rts_o), 32'(!pol));
    endtask : reply
    always @(posedge clk_i) begin
        if (wb_ack_o && !wb_we && exp_q.size() > 0)
            chk("read", wb_dat_o, exp_q.pop_front());
    end
    initial begin
        #(25 * 20000);
        err_total++;
        end_sim();
    end
    initial begin
        {wb_cyc, wb_stb, wb_we, send, slow} = 5'h00;
        wb_adr = 6'h00;
        wb_dat = 32'h0;
        seed = 32'h2B71AE0D;
        rst_i = 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int i = 0; i < 9; i++) rd(6'(i * 4), dflt[i]);
        rd(6'h28, 32'h0);
        bus(1'h1, 6'h10, 32'h0);
        lim(2'h0, 6'h00, 32'h21, 32'h1F);
        rd(6'h24, 32'h8);
        bus(1'h1, 6'h24, 32'hF);
        lim(2'h0, 6'h00, 32'h20, 32'h20);
        lim(2'h2, 6'h00, 32'h64, 32'h20);
        lim(2'h2, 6'h00, 32'h63, 32'h63);
        lim(2'h1, 6'h00, 32'hFF, 32'hFF);
        for (int i = 0; i < 4; i++) begin
            n = {$random(seed)} % 33;
            lim(2'h0, 6'h00, 32'(n), 32'(n));
        end
        lim(2'h0, 6'h14, 32'h04, 32'h05);
        lim(2'h0, 6'h14, 32'h42, 32'h05);
        lim(2'h0, 6'h20, 32'h65, 32'h14);
        lim(2'h1, 6'h20, 32'h64, 32'h64);
        lim(2'h2, 6'h20, 32'h385, 32'h64);
        lim(2'h2, 6'h20, 32'h384, 32'h384);
        lim(2'h0, 6'h04, 32'h5, 32'h3);
        lim(2'h0, 6'h08, 32'h3, 32'h0);
        lim(2'h0, 6'h1C, 32'h3, 32'h0);
        lim(2'h0, 6'h0C, 32'h4, 32'h3);
        lim(2'h1, 6'h0C, 32'h4, 32'h4);
        chk("stop_method", 32'(stop_method_o), 32'h4);
        bus(1'h1, 6'h04, 32'h4);
        bus(1'h1, 6'h08, 32'h2);
        bus(1'h1, 6'h1C, 32'h2);
        chk("protocol", 32'(protocol_o), 32'h2);
        chk("rate", 32'(bit_rate_o), 32'h3);
        chk("parity", 32'(parity_o), 32'h0);
        chk("station", 32'(station_addr_o), 32'h1F);
        bus(1'h1, 6'h1C, 32'h0);
        reply(5, 1'h1, 1'h0);
        bus(1'h1, 6'h14, 32'h41);
        reply(65, 1'h1, 1'h1);
        bus(1'h1, 6'h14, 32'h05);
        bus(1'h1, 6'h18, 32'h0);
        reply(5, 1'h0, 1'h0);
        chk("irq_masked", 32'(irq_o), 32'h0);
        bus(1'h1, 6'h20, 32'h2);
        bus(1'h1, 6'h2C, 32'h1);
        bus(1'h1, 6'h24, 32'hF);
        bus(1'h1, 6'h10, 32'h1);
        // Spacing stays under one tenth so no fault may build up
        for (int i = 0; i < 6; i++) begin
            repeat (20 + {$random(seed)} % 16) @(posedge clk_i);
            pulse_msg();
        end
        chk("fault_busy", 32'(comm_fault_o), 32'h0);
        n = 0;
        while (!comm_fault_o && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        // Fault only after more than two tenths of silence
        chk("fault_time", 32'(n >= 82 && n <= 123), 32'h1);
        repeat (2) @(posedge clk_i);
        chk("irq_fault", 32'(irq_o), 32'h1);
        bus(1'h1, 6'h10, 32'h0);
        bus(1'h1, 6'h24, 32'hF);
        repeat (200) @(posedge clk_i);
        chk("fault_off", 32'(comm_fault_o), 32'h0);
        chk("irq_off", 32'(irq_o), 32'h0);
        // One-edge reset applies the stored link settings
        bus(1'h1, 6'h00, 32'h0);
        rst_i <= 1'h1;
        @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        chk("rate_warm", 32'(bit_rate_o), 32'h4);
        chk("parity_warm", 32'(parity_o), 32'h2);
        chk("enable_warm", 32'(port_enable_o), 32'h0);
        rd(6'h30, 32'h1400);
        pulse_msg();
        n = 0;
        repeat (80) begin
            @(posedge clk_i);
            n += tx_go_o | rts_o;
        end
        chk("port_quiet", 32'(n), 32'h0);
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        chk("rate_rst", 32'(bit_rate_o), 32'h3);
        chk("station_rst", 32'(station_addr_o), 32'h1F);
        chk("enable_rst", 32'(port_enable_o), 32'h1);
        end_sim();
    end
endmodule : scs_supervisor_test
`default_nettype wire
